// [verilog/ddac_pkg.sv]
// constants, encodings and reset values for the dual converter input port
// assumes a 50 MHz ref_clk and a link clock far below half that rate
//
// Function
// - port A bits 9,8,7,6: power-down, core enable, stage two, stage one
// - latched power-down at 1 forces full power-down, core enable ignored
// - power-down 0: core enable 0 gives standby, 1 powers core up
// - stage one enable: 0 no interpolation, 1 twofold, if stage two is 0
// - stage two enable gives fourfold; host sets stage one with it
// - four-bit channel A gain trim from port A bits 5 down to 2
// - each channel port carries a 10-bit word, bit 9 most significant
// - clock pin is input with multiplier on, driven output with it off
// - interleave select high: both channels' words arrive on port A
// - interleave low: A taken on clock rise, B on clock fall
// - control fields taken from port A on strobe falling edge
// - clock multiplier enabled only while its enable pin is high
// - lock output high while multiplier locked to the clock pin
// - words captured on a rise reach the output on the next rise
`default_nettype none

package ddac_pkg;

    // ==========================================================
    // word layout
    localparam int WORD_W = 10;
    localparam int POS_POWER_DOWN = 9;
    localparam int POS_CORE_EN = 8;
    localparam int POS_STAGE2_EN = 7;
    localparam int POS_STAGE1_EN = 6;
    localparam int POS_GAIN_MSB = 5;
    localparam int POS_GAIN_LSB = 2;
    localparam int GAIN_W = 4;

    // ==========================================================
    // power states, one-hot
    typedef enum logic [2:0] {
        PWR_DOWN = 3'h1,
        PWR_STANDBY = 3'h2,
        PWR_ACTIVE = 3'h4
    } ddac_pwr_e;

    // interpolation factor codes
    localparam logic [1:0] INTERP_1X = 2'h0;
    localparam logic [1:0] INTERP_2X = 2'h1;
    localparam logic [1:0] INTERP_4X = 2'h2;

    // ==========================================================
    // reset values: powered down, no interpolation, zero trim
    localparam logic RST_POWER_DOWN = 1'h1;
    localparam logic RST_CORE_EN = 1'h0;
    localparam logic RST_STAGE_EN = 1'h0;
    localparam logic [3:0] RST_GAIN = 4'h0;
    localparam logic [9:0] RST_WORD = 10'h000;
    localparam logic RST_STROBE_N = 1'h1;

    // ==========================================================
    // timing
    localparam int REF_PERIOD_NS = 20;
    localparam int LINK_HALF_NS = 80;
    localparam int DIV_HALF_CYC = LINK_HALF_NS / REF_PERIOD_NS;
    localparam logic [1:0] DIV_LAST = 2'(DIV_HALF_CYC - 1);
    localparam int LOCK_WIN_NS = 640;
    localparam logic [5:0] LOCK_GAP =
        6'(LOCK_WIN_NS / REF_PERIOD_NS);
    localparam logic [2:0] LOCK_EDGES = 3'h4;

endpackage : ddac_pkg

`default_nettype wire

// [verilog/ddac_port_ctrl.sv]
// input port controller of the dual current-output converter
// assumes every pin input is asynchronous to ref_clk and that the
// link clock half period spans several ref_clk cycles
`default_nettype none

module ddac_port_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [9:0] portAWord,
    input wire logic [9:0] portBWord,
    input wire logic interleaveSelect,
    input wire logic controlWriteStrobeN,
    input wire logic multiplierEnablePin,
    input wire logic clkPinIn,
    output logic clkPinOut,
    output logic clkPinOe,
    output logic lockOut,
    output logic [2:0] powerState,
    output logic [1:0] interpMode,
    output logic [3:0] gainTrim,
    output logic [9:0] sampleA,
    output logic [9:0] sampleB,
    output logic sampleValid,
    input wire logic sampleReady,
    output logic overrun
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [9:0] aS1;
        logic [9:0] aS2;
        logic [9:0] bS1;
        logic [9:0] bS2;
        logic ileS1;
        logic ileS2;
        logic stbS1;
        logic stbS2;
        logic stbS3;
        logic enS1;
        logic enS2;
        logic ckS1;
        logic ckS2;
        logic ckS3;
        logic [1:0] divCnt;
        logic divClk;
        logic oe;
        logic multEn;
        logic powerDownField;
        logic coreEnableField;
        logic secondFilterEnable;
        logic firstFilterEnable;
        logic [3:0] gain;
        ddac_pkg::ddac_pwr_e pwr;
        logic [1:0] interp;
        logic [9:0] capA;
        logic [9:0] capB;
        logic pairValid;
        logic [9:0] e0a;
        logic [9:0] e0b;
        logic [9:0] e1a;
        logic [9:0] e1b;
        logic v0;
        logic v1;
        logic [5:0] gapCnt;
        logic [2:0] lockCnt;
        logic lock;
        logic ovr;
    } ddac_state_s;

    ddac_state_s st_reg;
    ddac_state_s st_next;

    // edge events from settled synchroniser stages, and the buffer pop and push
    logic linkRise;
    logic linkFall;
    logic strobeFall;
    logic pop;
    logic push;

    assign linkRise = st_reg.ckS2 & ~st_reg.ckS3;
    assign linkFall = ~st_reg.ckS2 & st_reg.ckS3;
    assign strobeFall = ~st_reg.stbS2 & st_reg.stbS3;
    assign pop = st_reg.v0 & sampleReady;
    assign push = linkRise & st_reg.pairValid;

    // ==========================================================
    // next state
    always_comb begin
        st_next = st_reg;

        // two-stage synchronisers on every pin input
        st_next.aS1 = portAWord;
        st_next.aS2 = st_reg.aS1;
        st_next.bS1 = portBWord;
        st_next.bS2 = st_reg.bS1;
        st_next.ileS1 = interleaveSelect;
        st_next.ileS2 = st_reg.ileS1;
        st_next.stbS1 = controlWriteStrobeN;
        st_next.stbS2 = st_reg.stbS1;
        st_next.stbS3 = st_reg.stbS2;
        st_next.enS1 = multiplierEnablePin;
        st_next.enS2 = st_reg.enS1;

        // own clock goes through the same path so data and edges align
        st_next.ckS1 = st_reg.multEn ? clkPinIn : st_reg.divClk;
        st_next.ckS2 = st_reg.ckS1;
        st_next.ckS3 = st_reg.ckS2;

        // multiplier enable and clock pin direction
        st_next.multEn = st_reg.enS2;
        st_next.oe = ~st_reg.enS2;

        // divider makes the link clock when the multiplier is off
        if (st_reg.divCnt == ddac_pkg::DIV_LAST) begin
            st_next.divCnt = 2'h0;
            st_next.divClk = ~st_reg.divClk;
        end else begin
            st_next.divCnt = st_reg.divCnt + 2'h1;
        end

        // control word load on strobe fall
        if (strobeFall) begin
            st_next.powerDownField =
                st_reg.aS2[ddac_pkg::POS_POWER_DOWN];
            st_next.coreEnableField =
                st_reg.aS2[ddac_pkg::POS_CORE_EN];
            st_next.secondFilterEnable =
                st_reg.aS2[ddac_pkg::POS_STAGE2_EN];
            st_next.firstFilterEnable =
                st_reg.aS2[ddac_pkg::POS_STAGE1_EN];
            st_next.gain = st_reg.aS2[ddac_pkg::POS_GAIN_MSB:
                ddac_pkg::POS_GAIN_LSB];
        end

        // power decode: power-down wins over core enable
        if (st_reg.powerDownField) begin
            st_next.pwr = ddac_pkg::PWR_DOWN;
        end else if (st_reg.coreEnableField) begin
            st_next.pwr = ddac_pkg::PWR_ACTIVE;
        end else begin
            st_next.pwr = ddac_pkg::PWR_STANDBY;
        end

        // stage two alone still yields 4x; host must set stage one too
        if (st_reg.secondFilterEnable) begin
            st_next.interp = ddac_pkg::INTERP_4X;
        end else if (st_reg.firstFilterEnable) begin
            st_next.interp = ddac_pkg::INTERP_2X;
        end else begin
            st_next.interp = ddac_pkg::INTERP_1X;
        end

        // capture: A on rise, B on fall, port A again when interleaved
        if (linkRise) begin
            st_next.capA = st_reg.aS2;
            st_next.pairValid = 1'h0;
        end
        if (linkFall) begin
            st_next.capB = st_reg.ileS2 ? st_reg.aS2
                : st_reg.bS2;
            st_next.pairValid = 1'h1;
        end

        // two-entry buffer, head entry flops drive the outputs directly
        if (pop) begin
            st_next.e0a = st_reg.e1a;
            st_next.e0b = st_reg.e1b;
            st_next.v0 = st_reg.v1;
            st_next.v1 = 1'h0;
        end
        if (push) begin
            if (!st_next.v0) begin
                st_next.e0a = st_reg.capA;
                st_next.e0b = st_reg.capB;
                st_next.v0 = 1'h1;
            end else if (!st_next.v1) begin
                st_next.e1a = st_reg.capA;
                st_next.e1b = st_reg.capB;
                st_next.v1 = 1'h1;
            end else begin
                // the pin cannot be stalled, so a full buffer drops
                st_next.ovr = 1'h1;
            end
        end

        // lock: enough regular rises with no gap beyond the window
        if (!st_reg.multEn) begin
            st_next.gapCnt = 6'h00;
            st_next.lockCnt = 3'h0;
        end else if (linkRise) begin
            st_next.gapCnt = 6'h00;
            if (st_reg.lockCnt != ddac_pkg::LOCK_EDGES) begin
                st_next.lockCnt = st_reg.lockCnt + 3'h1;
            end
        end else if (st_reg.gapCnt > ddac_pkg::LOCK_GAP) begin
            st_next.lockCnt = 3'h0;
        end else begin
            st_next.gapCnt = st_reg.gapCnt + 6'h01;
        end
        st_next.lock = st_reg.multEn
            & (st_reg.lockCnt == ddac_pkg::LOCK_EDGES)
            & (st_reg.gapCnt <= ddac_pkg::LOCK_GAP);
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.stbS1 <= ddac_pkg::RST_STROBE_N;
            st_reg.stbS2 <= ddac_pkg::RST_STROBE_N;
            st_reg.stbS3 <= ddac_pkg::RST_STROBE_N;
            st_reg.oe <= 1'h1;
            st_reg.powerDownField <= ddac_pkg::RST_POWER_DOWN;
            st_reg.coreEnableField <= ddac_pkg::RST_CORE_EN;
            st_reg.secondFilterEnable <= ddac_pkg::RST_STAGE_EN;
            st_reg.firstFilterEnable <= ddac_pkg::RST_STAGE_EN;
            st_reg.gain <= ddac_pkg::RST_GAIN;
            st_reg.pwr <= ddac_pkg::PWR_DOWN;
            st_reg.interp <= ddac_pkg::INTERP_1X;
            st_reg.capA <= ddac_pkg::RST_WORD;
            st_reg.capB <= ddac_pkg::RST_WORD;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs, each straight from a flop
    assign clkPinOut = st_reg.divClk;
    assign clkPinOe = st_reg.oe;
    assign lockOut = st_reg.lock;
    assign powerState = st_reg.pwr;
    assign interpMode = st_reg.interp;
    assign gainTrim = st_reg.gain;
    assign sampleA = st_reg.e0a;
    assign sampleB = st_reg.e0b;
    assign sampleValid = st_reg.v0;
    assign overrun = st_reg.ovr;

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // control bits land one cycle after the strobe fall is seen; checked a cycle later
    ctrl_map_a: assert property (strobeFall ##1 1'b1 |=>
        (st_reg.secondFilterEnable == $past(st_reg.aS2[7], 2))
        && (st_reg.firstFilterEnable == $past(st_reg.aS2[6], 2)))
        else $error("control bits not mapped from port A");

    gain_map_a: assert property (strobeFall |=>
        gainTrim == $past(st_reg.aS2[5:2]))
        else $error("gain trim not taken from port A bits 5..2");

    strobe_only_a: assert property (!strobeFall |=>
        $stable(gainTrim))
        else $error("gain trim changed without strobe");

    pd_wins_a: assert property (st_reg.powerDownField |=>
        powerState == ddac_pkg::PWR_DOWN)
        else $error("power-down not forced");

    standby_up_a: assert property (!st_reg.powerDownField |=>
        powerState == ($past(st_reg.coreEnableField)
        ? ddac_pkg::PWR_ACTIVE : ddac_pkg::PWR_STANDBY))
        else $error("standby or power-up decode wrong");

    interp_two_a: assert property (!st_reg.secondFilterEnable |=>
        interpMode == ($past(st_reg.firstFilterEnable)
        ? ddac_pkg::INTERP_2X : ddac_pkg::INTERP_1X))
        else $error("stage one interpolation wrong");

    interp_four_a: assert property (st_reg.secondFilterEnable |=>
        interpMode == ddac_pkg::INTERP_4X)
        else $error("fourfold interpolation not selected");

    pin_dir_a: assert property (##1 clkPinOe == !st_reg.multEn)
        else $error("clock pin direction wrong");

    mult_en_a: assert property (st_reg.enS2 |=> st_reg.multEn)
        else $error("multiplier enable does not follow pin");

    lock_needs_a: assert property (lockOut |->
        $past(st_reg.multEn)
        && ($past(st_reg.lockCnt) == ddac_pkg::LOCK_EDGES)
        && ($past(st_reg.gapCnt) <= ddac_pkg::LOCK_GAP))
        else $error("lock high without multiplier or enough edges");

    capt_a_a: assert property (linkRise |=>
        st_reg.capA == $past(st_reg.aS2))
        else $error("channel A not captured on rise");

    capt_b_a: assert property (linkFall && !st_reg.ileS2 |=>
        st_reg.capB == $past(st_reg.bS2))
        else $error("channel B not captured on fall");

    interleave_b_a: assert property (linkFall && st_reg.ileS2 |=>
        st_reg.capB == $past(st_reg.aS2))
        else $error("interleaved B word not taken from port A");

    out_next_a: assert property (push && !st_reg.v0 |=>
        sampleValid && sampleA == $past(st_reg.capA)
        && sampleB == $past(st_reg.capB))
        else $error("captured pair not moved out on next rise");

endmodule : ddac_port_ctrl

`default_nettype wire

// [tb/ddac_host_model.sv]
// host side model: sample words, control strobe and the clock pin drive
// assumes pinLevel is the resolved clock net seen by both parties
`default_nettype none

module ddac_host_model (
    input wire logic ref_clk,
    input wire logic pinLevel,
    input wire logic hostClkOn,
    input wire logic interleave,
    output var logic hostClk,
    output var logic [9:0] portA,
    output var logic [9:0] portB,
    output var logic strobeN
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [9:0] seqCount;
    logic ctrlBusy;

    // ==========================================================
    // clock pin drive, 160 ns, off the ref grid; stands still when off
    initial begin
        hostClk = 1'b0;
        portA = 10'h000;
        portB = 10'h3FF;
        strobeN = 1'b1;
        seqCount = 10'h3F0;
        ctrlBusy = 1'b0;
        #3;
        forever begin
            #80;
            if (hostClkOn) begin
                hostClk = ~hostClk;
            end
        end
    end

    // ==========================================================
    // words change 3 cycles after the opposite edge, so each one is
    // steady around the edge that takes it despite the sync lag
    always @(negedge pinLevel) begin
        repeat (3) @(posedge ref_clk);
        if (!ctrlBusy) begin
            seqCount <= seqCount + 10'h001;
            portA <= seqCount + 10'h001;
        end
    end

    // B word for the falling edge, on port A too when interleaved
    always @(posedge pinLevel) begin
        repeat (3) @(posedge ref_clk);
        portB <= ~seqCount;
        if (interleave && !ctrlBusy) begin
            portA <= ~seqCount;
        end
    end

    // control word held 4 cycles either side of the 4-cycle strobe low pulse
    task automatic writeCtrl(input logic [9:0] word);
        ctrlBusy = 1'b1;
        @(posedge ref_clk);
        portA <= word;
        repeat (4) @(posedge ref_clk);
        strobeN <= 1'b0;
        repeat (4) @(posedge ref_clk);
        strobeN <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ctrlBusy = 1'b0;
    endtask : writeCtrl

endmodule : ddac_host_model

`default_nettype wire

// [tb/ddac_port_ctrl_tb.sv]
// self-checking bench for the converter input port controller
// assumes the host model drives the pins and the board pulls the clock
// net low while neither party drives it
`default_nettype none

module ddac_port_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic rst = 1'b0;
    logic interleaveSelect = 1'b0;
    logic multiplierEnablePin = 1'b0;
    logic sampleReady = 1'b1;
    logic hostClkOn = 1'b0;
    wire logic hostClk, strobeN, pinLevel, clkPinOut, clkPinOe, lockOut;
    wire logic sampleValid, overrun;
    wire logic [9:0] portA, portB, sampleA, sampleB;
    wire logic [2:0] powerState;
    wire logic [1:0] interpMode;
    wire logic [3:0] gainTrim;
    int nFail = 0;
    int checked = 0;
    int pops = 0;
    int cycles = 0;
    logic [9:0] prevA;
    logic havePrev = 1'b0;
    logic chkOn = 1'b0;
    logic [9:0] words [6] = '{10'h3FC, 10'h200, 10'h114, 10'h060,
        10'h1C4, 10'h0C8};

    // ==========================================================
    // clock and the resolved clock net
    always #10 ref_clk = ~ref_clk;
    assign pinLevel = clkPinOe ? clkPinOut :
        (multiplierEnablePin ? hostClk : 1'b0);

    ddac_host_model host (.ref_clk(ref_clk), .pinLevel(pinLevel),
        .hostClkOn(hostClkOn), .interleave(interleaveSelect),
        .hostClk(hostClk), .portA(portA), .portB(portB),
        .strobeN(strobeN));

    ddac_port_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .portAWord(portA),
        .portBWord(portB), .interleaveSelect(interleaveSelect),
        .controlWriteStrobeN(strobeN),
        .multiplierEnablePin(multiplierEnablePin), .clkPinIn(pinLevel),
        .clkPinOut(clkPinOut), .clkPinOe(clkPinOe), .lockOut(lockOut),
        .powerState(powerState), .interpMode(interpMode),
        .gainTrim(gainTrim), .sampleA(sampleA), .sampleB(sampleB),
        .sampleValid(sampleValid), .sampleReady(sampleReady),
        .overrun(overrun));

    // ==========================================================
    // comparison and verdict
    task automatic check(input string what, input logic [9:0] seen,
        input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            nFail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finishTest();
        if (nFail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finishTest

    // hang guard, far above the thousand or so cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            nFail++;
            finishTest();
        end
    end

    // popped pairs: B is the inverse of A, A counts up with no gaps
    always @(posedge ref_clk) begin
        if (chkOn && sampleValid === 1'b1 && sampleReady) begin
            check("pairB", sampleB, ~sampleA);
            if (havePrev) begin
                check("seqA", sampleA, prevA + 10'h001);
            end
            prevA = sampleA;
            havePrev = 1'b1;
            pops++;
        end
    end

    // ==========================================================
    // scenarios
    task automatic ctrlCase(input logic [9:0] w);
        logic [2:0] pw;
        logic [1:0] im;
        pw = w[9] ? ddac_pkg::PWR_DOWN :
            (w[8] ? ddac_pkg::PWR_ACTIVE : ddac_pkg::PWR_STANDBY);
        im = w[7] ? ddac_pkg::INTERP_4X :
            (w[6] ? ddac_pkg::INTERP_2X : ddac_pkg::INTERP_1X);
        host.writeCtrl(w);
        check("power", 10'(powerState), 10'(pw));
        check("interp", 10'(interpMode), 10'(im));
        check("gain", 10'(gainTrim), 10'(w[5:2]));
    endtask : ctrlCase

    task automatic runStream(input logic il, input logic mul);
        chkOn <= 1'b0;
        interleaveSelect <= il;
        multiplierEnablePin <= mul;
        hostClkOn <= mul;
        repeat (60) @(posedge ref_clk);
        check("clkOe", 10'(clkPinOe), 10'(!mul));
        check("lock", 10'(lockOut), 10'(mul));
        havePrev = 1'b0;
        pops = 0;
        chkOn <= 1'b1;
        for (int i = 0; i < 200 && pops < 12; i++) @(posedge ref_clk);
        check("pops", 10'(pops >= 12), 10'h001);
        chkOn <= 1'b0;
    endtask : runStream

    task automatic stallOverrun();
        logic [9:0] held;
        sampleReady <= 1'b0;
        repeat (10) @(posedge ref_clk);
        held = sampleA;
        repeat (80) @(posedge ref_clk);
        check("stallValid", 10'(sampleValid), 10'h001);
        check("stallHold", sampleA, held);
        check("overrun", 10'(overrun), 10'h001);
        hostClkOn <= 1'b0;
        repeat (20) @(posedge ref_clk);
        sampleReady <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check("drained", 10'(sampleValid), 10'h000);
        check("sticky", 10'(overrun), 10'h001);
    endtask : stallOverrun

    // ==========================================================
    // main sequence
    initial begin
        // raised by a nonblocking write at time zero so the async reset sees a real edge
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("rstPower", 10'(powerState), 10'(ddac_pkg::PWR_DOWN));
        check("rstInterp", 10'(interpMode), 10'(ddac_pkg::INTERP_1X));
        check("rstOe", 10'(clkPinOe), 10'h001);
        check("rstValid", 10'({sampleValid, overrun}), 10'h000);
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (10) @(posedge ref_clk);
        foreach (words[i]) ctrlCase(words[i]);
        runStream(1'b0, 1'b0);
        runStream(1'b1, 1'b0);
        runStream(1'b0, 1'b1);
        runStream(1'b1, 1'b1);
        check("keep", 10'(powerState), 10'(ddac_pkg::PWR_STANDBY));
        stallOverrun();
        finishTest();
    end

endmodule : ddac_port_ctrl_tb

`default_nettype wire
